// ===== rtl/spcu_pkg.sv
// constants and types for the security page command unit
// assumes a single system clock of 250 MHz and an spi link in mode 0
package spcu_pkg;

	// ==========================================================
	// opcodes
	localparam logic [7:0] SPCU_OP_ERASE = 8'h44;
	localparam logic [7:0] SPCU_OP_PROG = 8'h42;
	localparam logic [7:0] SPCU_OP_READ = 8'h48;
	localparam logic [7:0] SPCU_OP_WREN = 8'h06;
	localparam logic [7:0] SPCU_OP_WRDI = 8'h04;

	// ==========================================================
	// address decoding
	localparam logic [7:0] SPCU_ADDR_TOP = 8'h00;
	localparam logic [7:0] SPCU_PAGE_FIRST = 8'h01;
	localparam logic [7:0] SPCU_PAGE_LAST = 8'h03;

	// ==========================================================
	// byte counts within a frame
	localparam logic [3:0] SPCU_CNT_OPC = 4'h0;
	localparam logic [3:0] SPCU_CNT_TOP = 4'h1;
	localparam logic [3:0] SPCU_CNT_MID = 4'h2;
	localparam logic [3:0] SPCU_CNT_LOW = 4'h3;
	localparam logic [3:0] SPCU_CNT_ADDR_DONE = 4'h4;
	localparam logic [3:0] SPCU_CNT_PROG_MIN = 4'h5;
	localparam logic [3:0] SPCU_CNT_MAX = 4'hF;
	localparam logic [2:0] SPCU_LK_DATA = 3'h5;
	localparam logic [2:0] SPCU_LK_MAX = 3'h7;
	localparam logic [2:0] SPCU_BIT_LAST = 3'h7;

	// ==========================================================
	// status bit positions
	localparam int SPCU_SR1_BUSY = 0;
	localparam int SPCU_SR1_WEL = 1;
	localparam int SPCU_SR1_PROT_LSB = 2;
	localparam int SPCU_SR2_LB1 = 3;
	localparam int SPCU_SR2_LB2 = 4;
	localparam int SPCU_SR2_LB3 = 5;
	localparam int SPCU_SR2_CMP = 6;

	// ==========================================================
	// values after reset, erased byte value and walk end
	localparam logic [6:0] SPCU_PROT_RST = 7'h00;
	localparam logic [2:0] SPCU_LOCK_RST = 3'h0;
	localparam logic SPCU_WEL_RST = 1'b0;
	localparam logic [7:0] SPCU_ERASED = 8'hFF;
	localparam logic [8:0] SPCU_WALK_END = 9'h100;

	// ==========================================================
	// timing
	localparam int SPCU_CLK_PERIOD_NS = 4;
	localparam int SPCU_ERASE_TIME_NS = 100000;
	localparam int SPCU_PROG_TIME_NS = 50000;
	localparam int SPCU_ERASE_CYCLES = SPCU_ERASE_TIME_NS / SPCU_CLK_PERIOD_NS;
	localparam int SPCU_PROG_CYCLES = SPCU_PROG_TIME_NS / SPCU_CLK_PERIOD_NS;

	// ==========================================================
	// engine states
	typedef enum logic [1:0] {SPCU_IDLE, SPCU_ERASING, SPCU_PROGRAMMING}
		spcu_state_t;

endpackage

// ===== rtl/spcu_top.sv
// security page command unit: erase, program and read of three pages
// assumes an spi host in mode 0 on SPI_SCK and a free running SYS_CLK
`timescale 1ns/10ps
`default_nettype none

module spcu_top
	import spcu_pkg::*;
#(
	parameter int ERASE_CYCLES = SPCU_ERASE_CYCLES,
	parameter int PROG_CYCLES = SPCU_PROG_CYCLES
) (
	// system clock and reset
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	// spi link
	input wire logic SPI_SCK,
	input wire logic SPI_CS_N,
	input wire logic SPI_SI,
	output logic SPI_SO,
	output logic SPI_SO_OE,
	// protection control
	input wire logic WP_N,
	input wire logic PROT_WR,
	input wire logic [6:0] PROT_WR_DATA,
	input wire logic [2:0] LOCK_SET,
	// status
	output logic [7:0] STATUS_BYTE1,
	output logic [7:0] STATUS_BYTE2
);

	localparam logic [23:0] erase_last = 24'(ERASE_CYCLES - 1);
	localparam logic [23:0] prog_last = 24'(PROG_CYCLES - 1);

	// ==========================================================
	// link domain
	logic [2:0] bit_cnt;
	logic [7:0] in_sh;
	logic [2:0] lk_bytes;
	logic [7:0] lk_opc;
	logic [7:0] byte_val;
	logic byte_tgl;
	logic mid_byte;
	logic [7:0] out_sh;
	logic [7:0] rd_data;

	// frame shifter, cleared by chip select, pure sck timing
	always_ff @(posedge SPI_SCK or posedge SPI_CS_N) begin
		if (SPI_CS_N) begin
			bit_cnt <= 3'h0;
			in_sh <= 8'h00;
			lk_bytes <= 3'h0;
			lk_opc <= 8'h00;
		end else begin
			bit_cnt <= 3'(bit_cnt + 3'h1);
			in_sh <= {in_sh[6:0], SPI_SI};
			if (bit_cnt == SPCU_BIT_LAST) begin
				if (lk_bytes != SPCU_LK_MAX)
					lk_bytes <= 3'(lk_bytes + 3'h1);
				if (lk_bytes == 3'h0)
					lk_opc <= {in_sh[6:0], SPI_SI};
			end
		end
	end

	// completed bytes and boundary flag kept past the frame end
	always_ff @(posedge SPI_SCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			byte_val <= 8'h00;
			byte_tgl <= 1'b0;
			mid_byte <= 1'b0;
			out_sh <= 8'h00;
		end else begin
			mid_byte <= (bit_cnt != SPCU_BIT_LAST); // boundary
			if (bit_cnt == SPCU_BIT_LAST) begin
				byte_val <= {in_sh[6:0], SPI_SI};
				byte_tgl <= ~byte_tgl;
				out_sh <= rd_data; // stable word, sys updates later
			end
		end
	end

	// serial out on falling edge, floats on release
	always_ff @(negedge SPI_SCK or posedge SPI_CS_N) begin
		if (SPI_CS_N) begin
			SPI_SO <= 1'b0;
			SPI_SO_OE <= 1'b0;
		end else begin
			SPI_SO_OE <= (lk_opc == SPCU_OP_READ) && (lk_bytes >= SPCU_LK_DATA);
			SPI_SO <= out_sh[3'(SPCU_BIT_LAST - bit_cnt)];
		end
	end

	// ==========================================================
	// crossings into the system domain
	logic cs_meta, cs_sync, cs_prev, cs_prev2;
	logic tgl_meta, tgl_sync, tgl_prev;
	logic mid_meta, mid_sync;
	logic wp_meta, wp_sync;

	// two flop synchronisers and edge history
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			{cs_meta, cs_sync, cs_prev, cs_prev2} <= 4'hF;
			{tgl_meta, tgl_sync, tgl_prev} <= 3'h0;
			{mid_meta, mid_sync} <= 2'h0;
			{wp_meta, wp_sync} <= 2'h0;
		end else begin
			{cs_meta, cs_sync, cs_prev, cs_prev2} <=
				{SPI_CS_N, cs_meta, cs_sync, cs_prev};
			{tgl_meta, tgl_sync, tgl_prev} <= {byte_tgl, tgl_meta, tgl_sync};
			{mid_meta, mid_sync} <= {mid_byte, mid_meta};
			{wp_meta, wp_sync} <= {WP_N, wp_meta};
		end
	end

	logic byte_evt, frame_start, frame_end;
	assign byte_evt = tgl_sync ^ tgl_prev;
	assign frame_start = cs_prev & ~cs_sync;
	// one cycle late so a final byte event is taken first
	assign frame_end = cs_prev & ~cs_prev2;

	// ==========================================================
	// storage and helpers
	logic [7:0] flash_mem [0:1023]; // three pages above page slot zero
	logic [7:0] buf_mem [0:255];
	logic [255:0] buf_mask;
	logic [2:0] lock_bits;
	logic [6:0] prot_bits;
	logic write_enable_latch;
	spcu_state_t state;

	// page number from top and middle bytes, zero when invalid
	function automatic logic [1:0] page_sel(input logic [7:0] top,
		input logic [7:0] mid);
		if (top == SPCU_ADDR_TOP && mid >= SPCU_PAGE_FIRST &&
			mid <= SPCU_PAGE_LAST)
			return mid[1:0];
		return 2'h0;
	endfunction

	// locked or invalid page
	function automatic logic page_blocked(input logic [1:0] pg,
		input logic [2:0] lk);
		case (pg)
			2'h1: return lk[0];
			2'h2: return lk[1];
			2'h3: return lk[2];
			default: return 1'b1;
		endcase
	endfunction

	// page slot zero has no storage and reads erased
	function automatic logic [7:0] mem_rd(input logic [9:0] idx);
		if (idx[9:8] == 2'h0)
			return SPCU_ERASED;
		return flash_mem[idx];
	endfunction

	// ==========================================================
	// frame byte capture
	logic [3:0] byte_cnt;
	logic [7:0] opc, addr_top, addr_mid;

	// opcode and address bytes in order
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			byte_cnt <= 4'h0;
			opc <= 8'h00;
			addr_top <= 8'h00;
			addr_mid <= 8'h00;
		end else if (frame_start) begin
			byte_cnt <= 4'h0;
			opc <= 8'h00;
		end else if (byte_evt) begin
			if (byte_cnt != SPCU_CNT_MAX)
				byte_cnt <= 4'(byte_cnt + 4'h1);
			case (byte_cnt)
				SPCU_CNT_OPC: opc <= byte_val;
				SPCU_CNT_TOP: addr_top <= byte_val;
				SPCU_CNT_MID: addr_mid <= byte_val;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// program buffer
	logic [7:0] col;
	logic buf_wr;
	assign buf_wr = byte_evt && opc == SPCU_OP_PROG && state == SPCU_IDLE &&
		byte_cnt >= SPCU_CNT_ADDR_DONE;

	// buffer valid mask cleared when a program address lands
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			buf_mask <= '0;
			col <= 8'h00;
		end else if (byte_evt && opc == SPCU_OP_PROG && state == SPCU_IDLE) begin
			if (byte_cnt == SPCU_CNT_LOW) begin
				buf_mask <= '0;
				col <= byte_val;
			end else if (buf_wr) begin
				buf_mask[col] <= 1'b1;
				col <= 8'(col + 8'h01); // wraps inside the page
			end
		end
	end

	// buffer data
	always_ff @(posedge SYS_CLK) begin
		if (buf_wr)
			buf_mem[col] <= byte_val;
	end

	// ==========================================================
	// read prefetch
	logic [9:0] rd_idx;
	logic rd_step;
	logic [9:0] rd_next;
	assign rd_step = byte_evt && opc == SPCU_OP_READ &&
		byte_cnt >= SPCU_CNT_ADDR_DONE;
	assign rd_next = 10'(rd_idx + 10'h001); // 3FFh rolls to 000h

	// next byte ready one whole byte before the link loads it
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			rd_idx <= 10'h000;
			rd_data <= 8'h00;
		end else if (byte_evt && opc == SPCU_OP_READ &&
			byte_cnt == SPCU_CNT_LOW) begin
			rd_idx <= {addr_mid[1:0], byte_val};
			rd_data <= mem_rd({addr_mid[1:0], byte_val});
		end else if (rd_step) begin
			rd_idx <= rd_next;
			rd_data <= mem_rd(rd_next);
		end
	end

	// ==========================================================
	// frame end decisions
	logic [1:0] pg;
	logic aligned, idle_end;
	logic go_erase, erase_abort, go_prog, prog_abort, wren_end, wrdi_end;
	assign pg = page_sel(addr_top, addr_mid); // low byte never used
	assign aligned = !mid_sync && byte_cnt != 4'h0;
	assign idle_end = frame_end && state == SPCU_IDLE;
	// erase only on exact address length at a boundary
	assign go_erase = idle_end && opc == SPCU_OP_ERASE && aligned &&
		byte_cnt == SPCU_CNT_ADDR_DONE && write_enable_latch && !page_blocked(pg, lock_bits);
	assign erase_abort = idle_end && opc == SPCU_OP_ERASE && !go_erase;
	// locked pages keep their contents
	assign go_prog = idle_end && opc == SPCU_OP_PROG && aligned &&
		byte_cnt >= SPCU_CNT_PROG_MIN && write_enable_latch &&
		!page_blocked(pg, lock_bits);
	assign prog_abort = idle_end && opc == SPCU_OP_PROG && !go_prog;
	assign wren_end = idle_end && opc == SPCU_OP_WREN && aligned;
	assign wrdi_end = idle_end && opc == SPCU_OP_WRDI && aligned;

	// ==========================================================
	// self timed engine
	logic [23:0] op_cnt;
	logic [8:0] walk;
	logic [1:0] op_page;
	logic op_done;
	assign op_done = (state == SPCU_ERASING && op_cnt == erase_last) ||
		(state == SPCU_PROGRAMMING && op_cnt == prog_last);

	// runs without link clocks once started
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			state <= SPCU_IDLE;
			op_cnt <= 24'h000000;
			walk <= 9'h000;
			op_page <= 2'h0;
		end else begin
			case (state)
				SPCU_IDLE: begin
					op_cnt <= 24'h000000;
					walk <= 9'h000;
					if (go_erase) begin
						state <= SPCU_ERASING;
						op_page <= pg;
					end else if (go_prog) begin
						state <= SPCU_PROGRAMMING;
						op_page <= pg;
					end
				end
				SPCU_ERASING, SPCU_PROGRAMMING: begin
					op_cnt <= 24'(op_cnt + 24'h000001);
					if (walk != SPCU_WALK_END)
						walk <= 9'(walk + 9'h001);
					if (op_done)
						state <= SPCU_IDLE;
				end
				default: state <= SPCU_IDLE;
			endcase
		end
	end

	// array update, one byte a cycle, no write protect gating
	always_ff @(posedge SYS_CLK) begin
		if (!walk[8] && state == SPCU_ERASING)
			flash_mem[{op_page, walk[7:0]}] <= SPCU_ERASED;
		else if (!walk[8] && state == SPCU_PROGRAMMING && buf_mask[walk[7:0]])
			flash_mem[{op_page, walk[7:0]}] <=
				flash_mem[{op_page, walk[7:0]}] & buf_mem[walk[7:0]];
	end

	// ==========================================================
	// write enable latch
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			write_enable_latch <= SPCU_WEL_RST;
		else if (op_done || erase_abort || prog_abort || wrdi_end)
			write_enable_latch <= 1'b0;
		else if (wren_end)
			write_enable_latch <= 1'b1;
	end

	// ==========================================================
	// protection and lock bits
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			prot_bits <= SPCU_PROT_RST;
			lock_bits <= SPCU_LOCK_RST;
		end else begin
			if (PROT_WR && wp_sync)
				prot_bits <= PROT_WR_DATA; // frozen while pin low
			lock_bits <= lock_bits | LOCK_SET; // set only, cleared by reset alone
		end
	end

	// ==========================================================
	// status bytes
	logic [7:0] next_sr1, next_sr2;
	always_comb begin
		next_sr1 = 8'h00;
		next_sr2 = 8'h00;
		next_sr1[SPCU_SR1_BUSY] = (state != SPCU_IDLE);
		next_sr1[SPCU_SR1_WEL] = write_enable_latch; // hardware owned
		next_sr1[SPCU_SR1_PROT_LSB +: 6] = prot_bits[5:0];
		next_sr2[SPCU_SR2_LB1] = lock_bits[0];
		next_sr2[SPCU_SR2_LB2] = lock_bits[1];
		next_sr2[SPCU_SR2_LB3] = lock_bits[2];
		next_sr2[SPCU_SR2_CMP] = prot_bits[6];
	end

	// registered status outputs
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			STATUS_BYTE1 <= 8'h00;
			STATUS_BYTE2 <= 8'h00;
		end else begin
			STATUS_BYTE1 <= next_sr1;
			STATUS_BYTE2 <= next_sr2;
		end
	end

	// ==========================================================
	// checks
	property p_wp_freeze;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(PROT_WR && !wp_sync) |=> (prot_bits == $past(prot_bits));
	endproperty
	a_wp_freeze: assert property (p_wp_freeze)
		else $error("protection bits changed under write protect");

	property p_lock_sticky;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		##1 ((lock_bits & $past(lock_bits)) == $past(lock_bits));
	endproperty
	a_lock_sticky: assert property (p_lock_sticky)
		else $error("lock bit cleared");

	property p_erase_needs_wel;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(state == SPCU_IDLE) ##1 (state == SPCU_ERASING) |-> $past(write_enable_latch);
	endproperty
	a_erase_needs_wel: assert property (p_erase_needs_wel)
		else $error("erase started without write enable");

	property p_erase_unlocked;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		go_erase |=> (state == SPCU_ERASING) && !page_blocked(op_page, lock_bits);
	endproperty
	a_erase_unlocked: assert property (p_erase_unlocked)
		else $error("erase of locked or invalid page");

	property p_busy_flag;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		go_erase |=> ##1 STATUS_BYTE1[SPCU_SR1_BUSY] [*4];
	endproperty
	a_busy_flag: assert property (p_busy_flag)
		else $error("busy not reported during erase");

	property p_abort_clears_wel;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		erase_abort |=> !write_enable_latch ##1 !STATUS_BYTE1[SPCU_SR1_WEL];
	endproperty
	a_abort_clears_wel: assert property (p_abort_clears_wel)
		else $error("aborted erase left write enable set");

	property p_done_clears;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		op_done |=> !write_enable_latch && state == SPCU_IDLE ##1
			!STATUS_BYTE1[SPCU_SR1_BUSY];
	endproperty
	a_done_clears: assert property (p_done_clears)
		else $error("finished operation left latch or busy set");

	property p_erase_bound;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(state == SPCU_ERASING) |-> (op_cnt <= erase_last);
	endproperty
	a_erase_bound: assert property (p_erase_bound)
		else $error("erase overran its time");

	property p_so_release;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		SPI_CS_N |-> !SPI_SO_OE;
	endproperty
	a_so_release: assert property (p_so_release)
		else $error("serial out driven with chip select high");

	property p_rd_wrap;
		@(posedge SYS_CLK) disable iff (SYS_RST)
		(rd_step && rd_idx == 10'h3FF) |=> (rd_idx == 10'h000);
	endproperty
	a_rd_wrap: assert property (p_rd_wrap)
		else $error("read did not wrap to start");

	c_erase: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
		go_erase);
	c_prog: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
		go_prog);
	c_wrap: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
		rd_step && rd_idx == 10'h3FF);
	c_abort: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
		erase_abort && write_enable_latch);

endmodule

`default_nettype wire

// ===== verif/spcu_spi_host.sv
// spi host model in mode 0 for the security page command unit
// assumes the bench calls its tasks one at a time from a single process
`timescale 1ns/10ps
`default_nettype none

module spcu_spi_host (
	// lines driven towards the device
	output logic sck,
	output logic cs_n,
	output logic si,
	// answer from the device
	input wire logic so,
	input wire logic so_oe
);
	// half period of the link clock, 48 ns period by default
	int half = 24;

	// ==========================================================
	// idle levels: clock stands low, device not selected
	// a clean select rise once every process waits clears the link shifter
	initial begin
		sck = 1'b0;
		cs_n = 1'b0;
		si = 1'b0;
		#1 cs_n = 1'b1;
	end

	// ==========================================================
	// frame control
	// select the device, offset keeps edges off the system clock
	task automatic frame_begin();
		#(half + 2.7) cs_n = 1'b0;
	endtask

	// shift n bits msb first, sample so on each rise
	task automatic shift(input logic [7:0] tx, input int n,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			si = tx[i];
			#(half) sck = 1'b1;
			rx[i] = so_oe ? so : 1'bx;
			#(half) sck = 1'b0;
		end
	endtask

	// release right after the last bit, then keep the gap
	task automatic frame_end();
		cs_n = 1'b1;
		si = ~si;
		#100;
	endtask
endmodule
`default_nettype wire

// ===== verif/tb_security_page_command_unit.sv
// self-checking bench for the security page command unit
// assumes spcu_pkg, spcu_top and the spi host model are compiled first
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp, msg) begin n_compared++; \
	if ((got) !== (exp)) begin n_mismatch++; \
	$display("wrong value at %0t: %s", $time, msg); end end

module tb_security_page_command_unit
	import spcu_pkg::*;
;
	localparam int CYC = 300;
	logic SYS_CLK = 1'b0;
	logic SYS_RST = 1'b0;
	logic SPI_SCK, SPI_CS_N, SPI_SI, SPI_SO, SPI_SO_OE;
	logic WP_N = 1'b1;
	logic PROT_WR = 1'b0;
	logic [6:0] PROT_WR_DATA = 7'h00;
	logic [2:0] LOCK_SET = 3'h0;
	logic [7:0] STATUS_BYTE1, STATUS_BYTE2;
	logic [7:0] rxq[$];
	int n_mismatch = 0;
	int n_compared = 0;

	// ==========================================================
	// clock, device and host
	always #2 SYS_CLK = ~SYS_CLK;

	spcu_top #(.ERASE_CYCLES(CYC), .PROG_CYCLES(CYC)) dut (
		.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .SPI_SCK(SPI_SCK),
		.SPI_CS_N(SPI_CS_N), .SPI_SI(SPI_SI), .SPI_SO(SPI_SO),
		.SPI_SO_OE(SPI_SO_OE), .WP_N(WP_N), .PROT_WR(PROT_WR),
		.PROT_WR_DATA(PROT_WR_DATA), .LOCK_SET(LOCK_SET),
		.STATUS_BYTE1(STATUS_BYTE1), .STATUS_BYTE2(STATUS_BYTE2));

	spcu_spi_host host (.sck(SPI_SCK), .cs_n(SPI_CS_N), .si(SPI_SI),
		.so(SPI_SO), .so_oe(SPI_SO_OE));

	// ==========================================================
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge SYS_CLK);
	endtask

	// one whole frame plus an optional ragged tail of bits
	task automatic frame(input logic [7:0] tx[$], input int extra,
		output logic [7:0] rx[$]);
		logic [7:0] b;
		rx = {};
		host.frame_begin();
		foreach (tx[i]) begin
			host.shift(tx[i], 8, b);
			rx.push_back(b);
		end
		if (extra > 0) host.shift(8'hFF, extra, b);
		host.frame_end();
	endtask

	// write enable first, as the device demands
	task automatic wren();
		frame('{SPCU_OP_WREN}, 0, rxq);
	endtask

	// poll busy with a bound instead of waiting the worst case
	task automatic wait_ready();
		int n;
		n = 0;
		while (STATUS_BYTE1[SPCU_SR1_BUSY] !== 1'b0 && n < CYC + 100) begin
			cyc(1);
			n++;
		end
		`CHK(n < CYC + 100, 1'b1, "busy never cleared")
	endtask

	task automatic read_chk(input logic [7:0] mid, low,
		input logic [7:0] exp[$]);
		logic [7:0] tx[$];
		logic [7:0] rx[$];
		tx = '{SPCU_OP_READ, SPCU_ADDR_TOP, mid, low, 8'h00};
		foreach (exp[i]) tx.push_back(8'hFF);
		frame(tx, 0, rx);
		foreach (exp[i]) `CHK(rx[i + 5], exp[i], "read data")
	endtask

	task automatic busy_is(input logic v);
		`CHK(STATUS_BYTE1[SPCU_SR1_BUSY], v, "busy flag")
	endtask

	task automatic wel_is(input logic v);
		`CHK(STATUS_BYTE1[SPCU_SR1_WEL], v, "write enable latch")
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		`CHK(STATUS_BYTE1, 8'h00, "status one after reset")
		`CHK(STATUS_BYTE2, 8'h00, "status two after reset")
		`CHK(SPI_SO_OE, 1'b0, "output enabled while idle")
	endtask

	// erase refused without latch, then each page erased
	task automatic t_erase();
		logic [7:0] p;
		frame('{SPCU_OP_ERASE, 8'h00, 8'h01, 8'h00}, 0, rxq);
		busy_is(1'b0);
		for (int i = 1; i <= 3; i++) begin
			p = 8'(i);
			wren();
			wel_is(1'b1);
			frame('{SPCU_OP_ERASE, 8'h00, p, p * 8'h55}, 0, rxq);
			busy_is(1'b1);
			wait_ready();
			wel_is(1'b0);
			read_chk(p, 8'h00, '{8'hFF, 8'hFF});
		end
	endtask

	// program with in-page wrap, then read across the register end
	task automatic t_program();
		wren();
		frame('{SPCU_OP_PROG, 8'h00, 8'h02, 8'hFE, 8'h11, 8'h22, 8'h33},
			0, rxq);
		busy_is(1'b1);
		wait_ready();
		wel_is(1'b0);
		read_chk(8'h02, 8'hFE, '{8'h11, 8'h22});
		read_chk(8'h02, 8'h00, '{8'h33, 8'hFF});
		wren();
		frame('{SPCU_OP_PROG, 8'h00, 8'h03, 8'hFF, 8'h5A}, 0, rxq);
		wait_ready();
		read_chk(8'h03, 8'hFE, '{8'hFF, 8'h5A, 8'hFF, 8'hFF});
	endtask

	// short address and ragged release both abort and drop the latch
	task automatic t_abort();
		wren();
		frame('{SPCU_OP_ERASE, 8'h00, 8'h02}, 0, rxq);
		busy_is(1'b0);
		wel_is(1'b0);
		wren();
		frame('{SPCU_OP_ERASE, 8'h00, 8'h02, 8'h00}, 3, rxq);
		busy_is(1'b0);
		wel_is(1'b0);
		read_chk(8'h02, 8'hFE, '{8'h11});
		// write disable drops the latch, so a later erase is refused
		wren();
		frame('{SPCU_OP_WRDI}, 0, rxq);
		wel_is(1'b0);
		frame('{SPCU_OP_ERASE, 8'h00, 8'h02, 8'h00}, 0, rxq);
		busy_is(1'b0);
	endtask

	// locked page refuses erase and program, unlocked page one still erases
	task automatic t_lock();
		@(negedge SYS_CLK) LOCK_SET = 3'h2;
		@(negedge SYS_CLK) LOCK_SET = 3'h0;
		cyc(4);
		`CHK(STATUS_BYTE2, 8'h10, "page two lock")
		wren();
		frame('{SPCU_OP_ERASE, 8'h00, 8'h02, 8'h00}, 0, rxq);
		busy_is(1'b0);
		wren();
		frame('{SPCU_OP_PROG, 8'h00, 8'h02, 8'h10, 8'h00}, 0, rxq);
		busy_is(1'b0);
		read_chk(8'h02, 8'hFE, '{8'h11, 8'h22});
		read_chk(8'h02, 8'h10, '{8'hFF});
		@(negedge SYS_CLK) LOCK_SET = 3'h4;
		@(negedge SYS_CLK) LOCK_SET = 3'h0;
		cyc(4);
		`CHK(STATUS_BYTE2, 8'h30, "both locks sticky")
		wren();
		frame('{SPCU_OP_ERASE, 8'h00, 8'h01, 8'h00}, 0, rxq);
		busy_is(1'b1);
		wait_ready();
	endtask

	task automatic prot(input logic [6:0] d);
		@(negedge SYS_CLK);
		PROT_WR = 1'b1;
		PROT_WR_DATA = d;
		@(negedge SYS_CLK) PROT_WR = 1'b0;
		cyc(4);
	endtask

	// write protect freezes protection bits only
	task automatic t_wp();
		@(negedge SYS_CLK) WP_N = 1'b0;
		cyc(4);
		prot(7'h55);
		`CHK(STATUS_BYTE1[7:2], 6'h00, "bits changed under protect")
		read_chk(8'h02, 8'hFE, '{8'h11});
		@(negedge SYS_CLK) WP_N = 1'b1;
		cyc(4);
		prot(7'h55);
		`CHK(STATUS_BYTE1[7:2], 6'h15, "protection bits")
		`CHK(STATUS_BYTE2[SPCU_SR2_CMP], 1'b1, "complement bit")
	endtask

	// slow clock read, then release in mid-byte
	task automatic t_release();
		logic [7:0] hdr[$];
		logic [7:0] b;
		host.half = 80;
		read_chk(8'h02, 8'hFE, '{8'h11, 8'h22});
		hdr = '{SPCU_OP_READ, 8'h00, 8'h02, 8'hFF, 8'h00};
		host.frame_begin();
		foreach (hdr[i]) host.shift(hdr[i], 8, b);
		host.shift(8'hFF, 3, b);
		`CHK(SPI_SO_OE, 1'b1, "output not driven")
		`CHK(b[7:5], 3'h1, "partial data bits")
		host.frame_end();
		`CHK(SPI_SO_OE, 1'b0, "output still driven")
		host.half = 24;
	endtask

	// ==========================================================
	// verdict and run control
	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#(100 * (CYC + 200) * 4);
		n_mismatch++;
		end_sim();
	end

	initial begin
		// a real rising edge, so the link side async clears take effect
		#1 SYS_RST = 1'b1;
		cyc(2);
		SYS_RST = 1'b0;
		cyc(6);
		t_reset();
		t_erase();
		t_program();
		t_abort();
		t_lock();
		t_wp();
		t_release();
		end_sim();
	end
endmodule
`default_nettype wire
